// ==== core/sdc_pkg.sv ====
// constants for the step/direction input and configuration block
package sdc_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 125;
	localparam int AUTOID_WINDOW_MS = 1000;
	localparam int AUTOID_CYCLES    = AUTOID_WINDOW_MS * 1000 * CLK_MHZ;
	localparam int AUTOID_CNT_W     = 28;

	// ----------------------------------------------------------------
	// switch fields and limits
	// ----------------------------------------------------------------
	localparam int         MSTEP_SEL_W   = 4;
	localparam int         CUR_SEL_W     = 3;
	localparam int         MSTEP_W       = 17;
	localparam int         CUR_W         = 7;
	localparam logic [16:0] MSTEP_MAX    = 17'h00200;
	localparam logic [6:0]  CUR_MIN_DA   = 7'h05;
	localparam logic [6:0]  CUR_MAX_DA   = 7'h38;
	localparam logic [16:0] SW_MSTEP_RST = 17'h00001;
	localparam logic [6:0]  SW_CUR_RST   = 7'h05;

	// microstep per revolution divisor from switch index (0 = software)
	function automatic logic [16:0] mstep_lookup(input logic [3:0] idx);
		logic [16:0] r;
		r = 17'h00000;
		case (idx)
			4'h1: r = 17'h00002;
			4'h2: r = 17'h00004;
			4'h3: r = 17'h00008;
			4'h4: r = 17'h00010;
			4'h5: r = 17'h00020;
			4'h6: r = 17'h00040;
			4'h7: r = 17'h00080;
			4'h8: r = 17'h00005;
			4'h9: r = 17'h0000A;
			4'hA: r = 17'h00014;
			4'hB: r = 17'h00019;
			4'hC: r = 17'h00028;
			4'hD: r = 17'h00032;
			4'hE: r = 17'h00064;
			4'hF: r = 17'h0007D;
			default: r = 17'h00000;
		endcase
		return r;
	endfunction

	// peak current in tenths of an amp from switch code (0 = software)
	function automatic logic [6:0] cur_lookup(input logic [2:0] code);
		logic [6:0] r;
		r = 7'h00;
		case (code)
			3'h1: r = 7'h15;
			3'h2: r = 7'h1B;
			3'h3: r = 7'h20;
			3'h4: r = 7'h26;
			3'h5: r = 7'h2B;
			3'h6: r = 7'h31;
			3'h7: r = 7'h38;
			default: r = 7'h00;
		endcase
		return r;
	endfunction
endpackage

// ==== core/sdc_autoid.sv ====
// double-toggle detector that requests motor auto-identification
`timescale 1ns/10ps
module sdc_autoid #(
	parameter int WINDOW_CYCLES = sdc_pkg::AUTOID_CYCLES
) (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic reset_n_i,
	// trigger switch
	input  wire logic trig_sw_i,
	// request pulse
	output logic      start_o
);
	typedef struct packed {
		logic                                trig_q;
		logic                                seeded;
		logic                                armed;
		logic [sdc_pkg::AUTOID_CNT_W-1:0]    cnt;
		logic                                start;
	} sdc_aid_st_t;

	sdc_aid_st_t st;
	sdc_aid_st_t next_st;
	logic        toggled;

	// first sample after reset only seeds the history, no false toggle
	assign toggled = st.seeded && (trig_sw_i != st.trig_q);

	always_comb begin
		next_st        = st;
		next_st.trig_q = trig_sw_i;
		next_st.seeded = 1'b1;
		next_st.start  = 1'b0;
		if (st.armed) begin
			if (st.cnt == sdc_pkg::AUTOID_CNT_W'(WINDOW_CYCLES - 1)) begin
				next_st.armed = 1'b0;
			end else begin
				next_st.cnt = st.cnt + sdc_pkg::AUTOID_CNT_W'(1);
			end
		end
		// R11 second change in window
		if (toggled) begin
			if (st.armed) begin
				next_st.start = 1'b1;
				next_st.armed = 1'b0;
			end else begin
				next_st.armed = 1'b1;
				next_st.cnt   = '0;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign start_o = st.start;
endmodule

// ==== core/sdc_top.sv ====
// step/direction command input and switch configuration of a stepper drive
`timescale 1ns/10ps
// Operation
// R01 - one microstep per selected step edge
// R02 - dual-pulse: step input is clockwise pulses
// R03 - direction level chooses rotation in step-direction
// R04 - dual-pulse: direction input is counter-clockwise
// R05 - controller keeps pulses above minimum width
// R06 - controller sets direction before step edge
// R07 - enable polarity by source, open means enabled
// R08 - software limits microsteps and current range
// R09 - switches five-eight pick microstep index
// R10 - switches one-three pick peak current
// R11 - two trigger toggles in one second
// R12 - controller limits step rate to maximum
// R13 - both fields default use software config
module sdc_top #(
	parameter int AUTOID_CYCLES = sdc_pkg::AUTOID_CYCLES
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	// command inputs from the motion controller
	input  wire logic        step_pulse_in_i,
	input  wire logic        direction_in_i,
	input  wire logic        drive_enable_in_i,
	// software configuration
	input  wire logic        cfg_dual_pulse_i,
	input  wire logic        cfg_step_falling_i,
	input  wire logic        cfg_cw_active_low_i,
	input  wire logic        cfg_ccw_active_low_i,
	input  wire logic        cfg_enable_active_low_i,
	input  wire logic [16:0] sw_mstep_i,
	input  wire logic [6:0]  sw_current_i,
	input  wire logic        sw_cfg_load_i,
	// switch bank
	input  wire logic        current_sel_bit0_i,
	input  wire logic        current_sel_bit1_i,
	input  wire logic        current_sel_bit2_i,
	input  wire logic        microstep_sel_bit0_i,
	input  wire logic        microstep_sel_bit1_i,
	input  wire logic        microstep_sel_bit2_i,
	input  wire logic        microstep_sel_bit3_i,
	input  wire logic        autoid_sw_i,
	// motion commands
	output logic             step_o,
	output logic             step_dir_ccw_o,
	output logic             drive_enabled_o,
	// active configuration
	output logic [16:0]      mstep_o,
	output logic [6:0]       current_o,
	output logic             sw_mode_o,
	output logic             cfg_reject_o,
	output logic             autoid_start_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        step_q;
		logic        dir_q;
		logic        seeded;
		logic        step;
		logic        dir_ccw;
		logic        enabled;
		logic [16:0] sw_mstep;
		logic [6:0]  sw_cur;
		logic [16:0] mstep;
		logic [6:0]  cur;
		logic        sw_mode;
		logic        reject;
		logic        autoid;
	} sdc_st_t;

	sdc_st_t     st;
	sdc_st_t     next_st;
	logic        autoid_pulse;
	logic [3:0]  mstep_idx;
	logic [2:0]  cur_code;
	logic        cw_edge;
	logic        ccw_edge;
	logic        dir_mode_step;
	logic        sw_cfg_ok;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// selected edge of the step input in step-direction mode
	function automatic logic sel_edge(input logic now, input logic prev, input logic falling);
		if (falling) begin
			return prev && !now;
		end
		return !prev && now;
	endfunction

	// entry into the active level of a pulse train; both samples use the
	// present polarity, so flipping polarity on an idle line is no edge
	function automatic logic train_edge(input logic now, input logic prev, input logic act_low);
		return (now ^ act_low) && !(prev ^ act_low);
	endfunction

	// one range test for both values, so a load lands whole or not at all
	function automatic logic cfg_in_range(input logic [16:0] m, input logic [6:0] c);
		return (m != 17'h00000) && (m <= sdc_pkg::MSTEP_MAX) &&
		       (c >= sdc_pkg::CUR_MIN_DA) && (c <= sdc_pkg::CUR_MAX_DA);
	endfunction

	// ----------------------------------------------------------------
	// switch decode
	// ----------------------------------------------------------------
	// R09 off counts one, position five lsb
	assign mstep_idx = ~{microstep_sel_bit3_i, microstep_sel_bit2_i,
	                     microstep_sel_bit1_i, microstep_sel_bit0_i};
	// R10 on counts one, position one lsb
	assign cur_code  = {current_sel_bit2_i, current_sel_bit1_i, current_sel_bit0_i};

	// dual-pulse trains, step-direction edge and the load range test
	assign cw_edge       = train_edge(step_pulse_in_i, st.step_q, cfg_cw_active_low_i);
	assign ccw_edge      = train_edge(direction_in_i, st.dir_q, cfg_ccw_active_low_i);
	assign dir_mode_step = sel_edge(step_pulse_in_i, st.step_q, cfg_step_falling_i);
	assign sw_cfg_ok     = cfg_in_range(sw_mstep_i, sw_current_i);

	sdc_autoid #(
		.WINDOW_CYCLES(AUTOID_CYCLES)
	) u_autoid (
		.mclk_i   (mclk_i),
		.reset_n_i(reset_n_i),
		.trig_sw_i(autoid_sw_i),
		.start_o  (autoid_pulse)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st        = st;
		next_st.step_q = step_pulse_in_i;
		next_st.dir_q  = direction_in_i;
		next_st.seeded = 1'b1;
		next_st.step   = 1'b0;
		next_st.reject = 1'b0;
		next_st.autoid = autoid_pulse;

		// R07 polarity set by source type
		next_st.enabled = drive_enable_in_i ^ cfg_enable_active_low_i;

		if (!cfg_dual_pulse_i) begin
			// R03 direction level picks rotation
			next_st.dir_ccw = direction_in_i;
			// R01 selected edge gives one step
			// edges closer than two clocks merge; minimum pulse width keeps them apart
			if (st.seeded && st.enabled) begin
				next_st.step = dir_mode_step;
			end
		end else if (st.seeded && st.enabled) begin
			// R02 clockwise train on step input
			// coincident edges: clockwise wins and the other edge is lost
			if (cw_edge) begin
				next_st.step    = 1'b1;
				next_st.dir_ccw = 1'b0;
			// R04 counter-clockwise train on direction input
			end else if (ccw_edge) begin
				next_st.step    = 1'b1;
				next_st.dir_ccw = 1'b1;
			end
		end

		// R08 software values range-checked, out of range refused
		if (sw_cfg_load_i) begin
			// a refused load keeps the previous pair in force
			if (!sw_cfg_ok) begin
				next_st.reject = 1'b1;
			end else begin
				next_st.sw_mstep = sw_mstep_i;
				next_st.sw_cur   = sw_current_i;
			end
		end

		// R13 default fields fall back to software values
		next_st.sw_mode = (mstep_idx == '0) && (cur_code == '0);
		if (mstep_idx == '0) begin
			next_st.mstep = st.sw_mstep;
		end else begin
			// R09 index selects microsteps
			next_st.mstep = sdc_pkg::mstep_lookup(mstep_idx);
		end
		if (cur_code == '0) begin
			next_st.cur = st.sw_cur;
		end else begin
			// R10 code selects peak current
			next_st.cur = sdc_pkg::cur_lookup(cur_code);
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// drive wakes at full step and minimum current until loaded or a switch field is set
			st          <= '0;
			st.sw_mstep <= sdc_pkg::SW_MSTEP_RST;
			st.sw_cur   <= sdc_pkg::SW_CUR_RST;
			st.mstep    <= sdc_pkg::SW_MSTEP_RST;
			st.cur      <= sdc_pkg::SW_CUR_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign step_o          = st.step;
	assign step_dir_ccw_o  = st.dir_ccw;
	assign drive_enabled_o = st.enabled;
	assign mstep_o         = st.mstep;
	assign current_o       = st.cur;
	assign sw_mode_o       = st.sw_mode;
	assign cfg_reject_o    = st.reject;
	assign autoid_start_o  = st.autoid;
endmodule

// ==== tb/sdc_top_properties.sv ====
// concurrent checks on the step/direction input block
`timescale 1ns/10ps
module sdc_top_properties (
	// watched inputs
	input wire logic        mclk_i,
	input wire logic        reset_n_i,
	input wire logic        step_pulse_in_i,
	input wire logic        direction_in_i,
	input wire logic        drive_enable_in_i,
	input wire logic        cfg_dual_pulse_i,
	input wire logic        cfg_step_falling_i,
	input wire logic        cfg_enable_active_low_i,
	input wire logic [16:0] sw_mstep_i,
	input wire logic [6:0]  sw_current_i,
	input wire logic        sw_cfg_load_i,
	// watched outputs
	input wire logic        step_o,
	input wire logic        step_dir_ccw_o,
	input wire logic        drive_enabled_o,
	input wire logic        cfg_reject_o,
	input wire logic        autoid_start_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	logic bad;
	assign bad = sw_mstep_i == 17'h00000 || sw_mstep_i > sdc_pkg::MSTEP_MAX
		|| sw_current_i < sdc_pkg::CUR_MIN_DA || sw_current_i > sdc_pkg::CUR_MAX_DA;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	property p_step_edge; !cfg_dual_pulse_i && drive_enabled_o
		&& (cfg_step_falling_i ? $fell(step_pulse_in_i) : $rose(step_pulse_in_i)) |=> step_o; endproperty
	a_step_edge: assert property (p_step_edge) else $error("step missed");
	property p_step_dir; !cfg_dual_pulse_i && step_o |-> step_dir_ccw_o == $past(direction_in_i); endproperty
	a_step_dir: assert property (p_step_dir) else $error("wrong direction");
	property p_step_once; step_o |=> !step_o; endproperty
	a_step_once: assert property (p_step_once) else $error("step too long");
	property p_step_gated; !drive_enabled_o |=> !step_o; endproperty
	a_step_gated: assert property (p_step_gated) else $error("step while disabled");
	property p_enable; 1'b1 |=> drive_enabled_o == ($past(drive_enable_in_i) ^ $past(cfg_enable_active_low_i)); endproperty
	a_enable: assert property (p_enable) else $error("enable level wrong");
	property p_rej_bad; sw_cfg_load_i && bad |=> cfg_reject_o; endproperty
	a_rej_bad: assert property (p_rej_bad) else $error("bad load kept");
	property p_rej_good; !(sw_cfg_load_i && bad) |=> !cfg_reject_o; endproperty
	a_rej_good: assert property (p_rej_good) else $error("good load refused");
	property p_aid_once; autoid_start_o |=> !autoid_start_o; endproperty
	a_aid_once: assert property (p_aid_once) else $error("auto-id pulse too long");
endmodule
bind sdc_top sdc_top_properties u_props (
	.mclk_i, .reset_n_i, .step_pulse_in_i, .direction_in_i, .drive_enable_in_i,
	.cfg_dual_pulse_i, .cfg_step_falling_i, .cfg_enable_active_low_i, .sw_mstep_i,
	.sw_current_i, .sw_cfg_load_i, .step_o, .step_dir_ccw_o, .drive_enabled_o,
	.cfg_reject_o, .autoid_start_o
);

// ==== tb/sdc_ctrl_model.sv ====
// motion controller model driving the step and direction lines
`timescale 1ns/10ps
module sdc_ctrl_model (
	// clock
	input  wire logic mclk_i,
	// command lines
	output logic      step_o,
	output logic      dir_o
);
	// ----------------------------------------------------------------
	// pulse tasks
	// ----------------------------------------------------------------
	initial begin
		step_o = 1'b0;
		dir_o = 1'b0;
	end
	task automatic go(input logic d, input int w);
		@(posedge mclk_i);
		dir_o <= d;
		repeat (625) @(posedge mclk_i);
		// w of 313 keeps 2.5 us width; with the 5 us setup a step takes 10 us, 100 kHz
		step_o <= 1'b1;
		repeat (w) @(posedge mclk_i);
		step_o <= 1'b0;
		repeat (w) @(posedge mclk_i);
	endtask
	task automatic ccw(input int w);
		dir_o <= 1'b1;
		repeat (w) @(posedge mclk_i);
		dir_o <= 1'b0;
		repeat (w) @(posedge mclk_i);
	endtask
endmodule

// ==== tb/step_dir_input_config_tb.sv ====
// self-checking bench for the step/direction input block
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module step_dir_input_config_tb;
	logic        mclk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        enable_in = 1'b1;
	logic        cwl = 1'b0;
	logic        ccwl = 1'b0;
	logic        dual = 1'b0;
	logic        fall = 1'b0;
	logic        enl = 1'b0;
	logic        ld = 1'b0;
	logic        aid = 1'b0;
	logic [16:0] smst = 17'h00001;
	logic [6:0]  scur = 7'h05;
	logic [2:0]  cs = 3'h0;
	logic [3:0]  ms = 4'hF;
	logic        stp, stp_in, dir_in, ccw, en, swm, rej, aid_o;
	logic [16:0] mst;
	logic [6:0]  cur;
	int          n_fail = 0;
	int          n_compared = 0;
	int          n_step = 0;
	int          n_aid = 0;
	logic [16:0] mt [16] = '{17'h00001, 17'h00002, 17'h00004, 17'h00008, 17'h00010, 17'h00020, 17'h00040,
		17'h00080, 17'h00005, 17'h0000A, 17'h00014, 17'h00019, 17'h00028, 17'h00032, 17'h00064, 17'h0007D};
	logic [6:0]  ct [8] = '{7'h05, 7'h15, 7'h1B, 7'h20, 7'h26, 7'h2B, 7'h31, 7'h38};
	initial forever #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		n_step += stp;
		n_aid += aid_o;
	end
	sdc_ctrl_model ctl (.mclk_i(mclk_i), .step_o(stp_in), .dir_o(dir_in));
	sdc_top #(.AUTOID_CYCLES(50)) dut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .step_pulse_in_i(stp_in), .direction_in_i(dir_in),
		.drive_enable_in_i(enable_in), .cfg_dual_pulse_i(dual), .cfg_step_falling_i(fall),
		.cfg_cw_active_low_i(cwl), .cfg_ccw_active_low_i(ccwl), .cfg_enable_active_low_i(enl),
		.sw_mstep_i(smst), .sw_current_i(scur), .sw_cfg_load_i(ld),
		.current_sel_bit0_i(cs[0]), .current_sel_bit1_i(cs[1]), .current_sel_bit2_i(cs[2]),
		.microstep_sel_bit0_i(ms[0]), .microstep_sel_bit1_i(ms[1]), .microstep_sel_bit2_i(ms[2]),
		.microstep_sel_bit3_i(ms[3]), .autoid_sw_i(aid), .step_o(stp), .step_dir_ccw_o(ccw),
		.drive_enabled_o(en), .mstep_o(mst), .current_o(cur), .sw_mode_o(swm), .cfg_reject_o(rej),
		.autoid_start_o(aid_o));
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic t_step(input logic d, input int w);
		int n;
		n = n_step;
		ctl.go(d, w);
		`CHK(n_step, n + 1)
		`CHK(ccw, d)
	endtask
	task automatic t_dual;
		int n;
		dual <= 1'b1;
		// both active levels of the two trains
		for (int p = 0; p < 2; p++) begin
			cwl <= 1'(p);
			ccwl <= 1'(p);
			t_step(1'b0, 313);
			n = n_step;
			ctl.ccw(313);
			`CHK(n_step, n + 1)
			`CHK(ccw, 1'b1)
		end
		cwl <= 1'b0;
		ccwl <= 1'b0;
		dual <= 1'b0;
	endtask
	task automatic t_enable;
		int n;
		n = n_step;
		enable_in <= 1'b0;
		cyc(2);
		`CHK(en, 1'b0)
		ctl.go(1'b0, 313);
		`CHK(n_step, n)
		enl <= 1'b1;
		cyc(2);
		`CHK(en, 1'b1)
		enl <= 1'b0;
		enable_in <= 1'b1;
	endtask
	task automatic t_switch;
		for (int i = 0; i < 16; i++) begin
			ms <= ~4'(i);
			cyc(3);
			`CHK(mst, mt[i])
			`CHK(swm, 1'(i == 0))
		end
		for (int i = 0; i < 8; i++) begin
			cs <= 3'(i);
			cyc(3);
			`CHK(cur, ct[i])
		end
		ms <= 4'hF;
		cs <= 3'h0;
		cyc(3);
	endtask
	task automatic load(input logic [16:0] m, input logic [6:0] c, input logic r);
		smst <= m;
		scur <= c;
		ld <= 1'b1;
		@(posedge mclk_i);
		ld <= 1'b0;
		@(posedge mclk_i);
		`CHK(rej, r)
		cyc(2);
	endtask
	task automatic t_load;
		load(17'h00200, 7'h38, 1'b0);
		load(17'h00201, 7'h38, 1'b1);
		load(17'h00001, 7'h04, 1'b1);
		`CHK(mst, 17'h00200)
		`CHK(cur, 7'h38)
	endtask
	task automatic t_autoid;
		int a;
		a = n_aid;
		aid <= 1'b1;
		cyc(10);
		aid <= 1'b0;
		cyc(4);
		`CHK(n_aid, a + 1)
		aid <= 1'b1;
		cyc(60);
		aid <= 1'b0;
		cyc(60);
		`CHK(n_aid, a + 1)
	endtask
	task automatic test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		test_done;
	end
	initial begin
		cyc(9);
		`CHK(mst, 17'h00001)
		`CHK(cur, 7'h05)
		cyc(1);
		reset_n_i <= 1'b1;
		cyc(2);
		t_step(1'b1, 313);
		fall <= 1'b1;
		t_step(1'b0, 400);
		fall <= 1'b0;
		t_dual;
		t_enable;
		t_switch;
		t_load;
		t_autoid;
		test_done;
	end
endmodule
